// ---- design/weigh_meas_mem.v ----
// weigh_meas_mem.v: simple dual-port store for per-scale measurements.
// assumes: one write port from the weighing engine, one read port from the
// register bank; read data is registered, old data on same-address collision.
`timescale 1ns/1ps
module weigh_meas_mem
#(
   parameter DW = 16,
   parameter AW = 5
)
(
   input wire i_clk,
   input wire i_we,
   input wire [AW-1:0] i_waddr,
   input wire [DW-1:0] i_wdata,
   input wire [AW-1:0] i_raddr,
   output wire [DW-1:0] o_rdata
);

reg [DW-1:0] mem [0:(1<<AW)-1];
reg [DW-1:0] rdata_ff;
integer k;

// ----------------------------------------------------------------------
// storage, cleared at start of simulation
// ----------------------------------------------------------------------
initial
begin
   for (k = 0; k < (1<<AW); k = k + 1)
   begin
      mem[k] = {DW{1'b0}};
   end
   rdata_ff = {DW{1'b0}};
end

always @(posedge i_clk)
begin
   if (i_we)
   begin
      mem[i_waddr] <= i_wdata;
   end
   rdata_ff <= mem[i_raddr];
end

assign o_rdata = rdata_ff;

endmodule

// ---- design/weigh_status_bank.v ----
// weigh_status_bank.v: read-only status register bank of a multi-channel
// weighing instrument, read by the protocol slave over a simple read port.
// assumes: all inputs synchronous to I_CLK; measurement values arrive already
// scaled (signal and analog values in thousandths) from the weighing engine.
//
// Contract
// - gross weight per scale, valid when error zero
// - net weight per scale, valid when error zero
// - flow rate per scale, valid when error zero
// - input signal in mV/V per scale
// - four analog output values, three decimals
// - input word A: inputs 11-18, 21-28
// - input word B: inputs 31-38, 41-48
// - input word C: inputs 51-58, 61-68
// - output word A: outputs 11-18, 21-28
// - output word B: outputs 31-38, 41-48
// - output word C: outputs 51-58, 61-68
// - level bit n set above level n+1
// - level bit n set above level n+17
// - error code zero means none, 0-255
`timescale 1ns/1ps
`include "weigh_status_consts.vh"
module weigh_status_bank
#(
   parameter DW = `WS_DATA_W,
   parameter AW = `WS_ADDR_W,
   parameter EW = `WS_ERR_W,
   parameter NLEV = `WS_LEVELS
)
(
   input wire I_CLK,
   input wire I_RST,
   input wire i_meas_we,
   input wire [`WS_SCALE_W-1:0] i_meas_scale,
   input wire [`WS_SEL_W-1:0] i_meas_sel,
   input wire [DW-1:0] i_meas_data,
   input wire [DW-1:0] i_aout1,
   input wire [DW-1:0] i_aout2,
   input wire [DW-1:0] i_aout3,
   input wire [DW-1:0] i_aout4,
   input wire [DW-1:0] i_din_a,
   input wire [DW-1:0] i_din_b,
   input wire [DW-1:0] i_din_c,
   input wire [DW-1:0] i_dout_a,
   input wire [DW-1:0] i_dout_b,
   input wire [DW-1:0] i_dout_c,
   input wire [DW-1:0] i_level_weight,
   input wire [NLEV*DW-1:0] i_level_limits,
   input wire i_rd_req,
   input wire [AW-1:0] i_rd_addr,
   output wire o_rd_valid,
   output wire [DW-1:0] o_rd_data,
   output wire o_rd_illegal,
   output wire o_rd_err_zero
);

// ----------------------------------------------------------------------
// live samples of i/o and analog state
// ----------------------------------------------------------------------
reg [DW-1:0] aout1_ff;
reg [DW-1:0] aout2_ff;
reg [DW-1:0] aout3_ff;
reg [DW-1:0] aout4_ff;
reg [DW-1:0] in_a_ff;
reg [DW-1:0] in_b_ff;
reg [DW-1:0] in_c_ff;
reg [DW-1:0] out_a_ff;
reg [DW-1:0] out_b_ff;
reg [DW-1:0] out_c_ff;
reg [NLEV-1:0] level_ff;
wire [NLEV-1:0] nxt_level;

always @(posedge I_CLK or posedge I_RST)
begin
   if (I_RST)
   begin
      aout1_ff <= `WS_RST_WORD;
      aout2_ff <= `WS_RST_WORD;
      aout3_ff <= `WS_RST_WORD;
      aout4_ff <= `WS_RST_WORD;
      in_a_ff <= `WS_RST_WORD;
      in_b_ff <= `WS_RST_WORD;
      in_c_ff <= `WS_RST_WORD;
      out_a_ff <= `WS_RST_WORD;
      out_b_ff <= `WS_RST_WORD;
      out_c_ff <= `WS_RST_WORD;
      level_ff <= {NLEV{1'b0}};
   end
   else
   begin
      aout1_ff <= i_aout1;
      aout2_ff <= i_aout2;
      aout3_ff <= i_aout3;
      aout4_ff <= i_aout4;
      in_a_ff <= i_din_a;
      in_b_ff <= i_din_b;
      in_c_ff <= i_din_c;
      out_a_ff <= i_dout_a;
      out_b_ff <= i_dout_b;
      out_c_ff <= i_dout_c;
      level_ff <= nxt_level;
   end
end

// ----------------------------------------------------------------------
// level comparators, signed weight strictly above each limit
// ----------------------------------------------------------------------
genvar g;
generate
   for (g = 0; g < NLEV; g = g + 1)
   begin : lev
      assign nxt_level[g] = $signed(i_level_weight) > $signed(i_level_limits[g*DW +: DW]);
   end
endgenerate

// ----------------------------------------------------------------------
// error codes per scale, held in flops for a quick validity check
// ----------------------------------------------------------------------
reg [EW-1:0] err_ff [0:`WS_SCALES-1];
integer s;

always @(posedge I_CLK or posedge I_RST)
begin
   if (I_RST)
   begin
      for (s = 0; s < `WS_SCALES; s = s + 1)
      begin
         err_ff[s] <= `WS_RST_ERR;
      end
   end
   else if (i_meas_we && i_meas_sel == `WS_SEL_ERROR)
   begin
      err_ff[i_meas_scale] <= i_meas_data[EW-1:0];
   end
end

// ----------------------------------------------------------------------
// measurement store: gross, net, flow, signal per scale
// ----------------------------------------------------------------------
wire meas_mem_we;
wire [`WS_MEM_AW-1:0] meas_waddr;
wire [`WS_MEM_AW-1:0] meas_raddr;
wire [DW-1:0] meas_rdata;

assign meas_mem_we = i_meas_we && (i_meas_sel <= `WS_SEL_SIGNAL);
assign meas_waddr = {i_meas_scale, i_meas_sel[1:0]};
assign meas_raddr = {i_rd_addr[5:3], i_rd_addr[1:0]};

weigh_meas_mem
#(
   .DW(DW),
   .AW(`WS_MEM_AW)
)
u_meas_mem
(
   .i_clk(I_CLK),
   .i_we(meas_mem_we),
   .i_waddr(meas_waddr),
   .i_wdata(i_meas_data),
   .i_raddr(meas_raddr),
   .o_rdata(meas_rdata)
);

// ----------------------------------------------------------------------
// read stage 1: decode and pick non-memory value
// ----------------------------------------------------------------------
reg p1_valid_ff;
reg p1_mem_ff;
reg p1_illegal_ff;
reg p1_err_zero_ff;
reg [DW-1:0] p1_data_ff;
reg nxt_mem;
reg nxt_illegal;
reg [DW-1:0] nxt_data;
wire [`WS_SCALE_W-1:0] rd_scale;
wire [`WS_SEL_W-1:0] rd_sel;
wire rd_in_scale;

assign rd_scale = i_rd_addr[5:3];
assign rd_sel = i_rd_addr[2:0];
assign rd_in_scale = (i_rd_addr <= `WS_SCALE_END);

always @*
begin
   nxt_mem = 1'b0;
   nxt_illegal = 1'b0;
   nxt_data = `WS_RST_WORD;
   if (rd_in_scale)
   begin
      if (rd_sel <= `WS_SEL_SIGNAL)
      begin
         nxt_mem = 1'b1;
      end
      else if (rd_sel == `WS_SEL_ERROR)
      begin
         nxt_data = {{(DW-EW){1'b0}}, err_ff[rd_scale]};
      end
      else
      begin
         nxt_illegal = 1'b1;
      end
   end
   else
   begin
      case (i_rd_addr)
         `WS_OFS_AOUT1: nxt_data = aout1_ff;
         `WS_OFS_AOUT2: nxt_data = aout2_ff;
         `WS_OFS_AOUT3: nxt_data = aout3_ff;
         `WS_OFS_AOUT4: nxt_data = aout4_ff;
         `WS_OFS_IN_A: nxt_data = in_a_ff;
         `WS_OFS_IN_B: nxt_data = in_b_ff;
         `WS_OFS_IN_C: nxt_data = in_c_ff;
         `WS_OFS_OUT_A: nxt_data = out_a_ff;
         `WS_OFS_OUT_B: nxt_data = out_b_ff;
         `WS_OFS_OUT_C: nxt_data = out_c_ff;
         `WS_OFS_LEVEL_LO: nxt_data = level_ff[DW-1:0];
         `WS_OFS_LEVEL_HI: nxt_data = level_ff[2*DW-1:DW];
         default: nxt_illegal = 1'b1;
      endcase
   end
end

// ----------------------------------------------------------------------
// validity flag, only for mapped per-scale registers
// ----------------------------------------------------------------------
wire rd_scale_err_zero;

assign rd_scale_err_zero = rd_in_scale && !nxt_illegal
   && (err_ff[rd_scale] == `WS_RST_ERR);

always @(posedge I_CLK or posedge I_RST)
begin
   if (I_RST)
   begin
      p1_valid_ff <= 1'b0;
      p1_mem_ff <= 1'b0;
      p1_illegal_ff <= 1'b0;
      p1_err_zero_ff <= 1'b0;
      p1_data_ff <= `WS_RST_WORD;
   end
   else
   begin
      p1_valid_ff <= i_rd_req;
      p1_mem_ff <= nxt_mem;
      p1_illegal_ff <= nxt_illegal;
      p1_err_zero_ff <= rd_scale_err_zero;
      p1_data_ff <= nxt_data;
   end
end

// ----------------------------------------------------------------------
// read stage 2: registered answer, no side effect on any state
// ----------------------------------------------------------------------
reg rd_valid_ff;
reg rd_illegal_ff;
reg rd_err_zero_ff;
reg [DW-1:0] rd_data_ff;

always @(posedge I_CLK or posedge I_RST)
begin
   if (I_RST)
   begin
      rd_valid_ff <= 1'b0;
      rd_illegal_ff <= 1'b0;
      rd_err_zero_ff <= 1'b0;
      rd_data_ff <= `WS_RST_WORD;
   end
   else
   begin
      rd_valid_ff <= p1_valid_ff;
      rd_illegal_ff <= p1_valid_ff && p1_illegal_ff;
      rd_err_zero_ff <= p1_valid_ff && p1_err_zero_ff;
      if (p1_valid_ff)
      begin
         rd_data_ff <= p1_mem_ff ? meas_rdata : p1_data_ff;
      end
   end
end

assign o_rd_valid = rd_valid_ff;
assign o_rd_data = rd_data_ff;
assign o_rd_illegal = rd_illegal_ff;
assign o_rd_err_zero = rd_err_zero_ff;

endmodule

// ---- design/weigh_status_consts.vh ----
// weigh_status_consts.vh: address map, field positions and sizes of the
// read-only weighing status register bank.
// assumes: included by its bare name by the bank; its memory does not include it.
`ifndef WEIGH_STATUS_CONSTS_VH
`define WEIGH_STATUS_CONSTS_VH

// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define WS_DATA_W 16
`define WS_ADDR_W 16
`define WS_ERR_W 8
`define WS_SCALES 8
`define WS_SCALE_W 3
`define WS_SEL_W 3
`define WS_LEVELS 32
`define WS_MEM_AW 5

// ----------------------------------------------------------------------
// per-scale slot codes, address = scale * 8 + slot
// ----------------------------------------------------------------------
`define WS_SEL_GROSS 3'h0
`define WS_SEL_NET 3'h1
`define WS_SEL_FLOW 3'h2
`define WS_SEL_SIGNAL 3'h3
`define WS_SEL_ERROR 3'h4
`define WS_SCALE_BASE 16'h0000
`define WS_SCALE_END 16'h003F

// ----------------------------------------------------------------------
// shared register offsets
// ----------------------------------------------------------------------
`define WS_OFS_AOUT1 16'h0040
`define WS_OFS_AOUT2 16'h0041
`define WS_OFS_AOUT3 16'h0042
`define WS_OFS_AOUT4 16'h0043
`define WS_OFS_IN_A 16'h0050
`define WS_OFS_IN_B 16'h0051
`define WS_OFS_IN_C 16'h0052
`define WS_OFS_OUT_A 16'h0053
`define WS_OFS_OUT_B 16'h0054
`define WS_OFS_OUT_C 16'h0055
`define WS_OFS_LEVEL_LO 16'h0056
`define WS_OFS_LEVEL_HI 16'h0057

// ----------------------------------------------------------------------
// field positions inside an i/o status word
// ----------------------------------------------------------------------
`define WS_GRP_LO_LSB 0
`define WS_GRP_HI_LSB 8
`define WS_GRP_W 8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define WS_RST_WORD 16'h0000
`define WS_RST_ERR 8'h00

`endif

// ---- tb/tb_top.sv ----
// testbench: live words, measurements, levels and refusals
// assumes: master model drives the read port
`timescale 1ns/1ps
module tb_top;
   reg I_CLK = 1'b0;
   reg I_RST = 1'b1;
   reg we = 1'b0;
   reg [2:0] sc = 3'h0;
   reg [2:0] sl = 3'h0;
   reg [15:0] md = 16'h0000;
   reg [15:0] lv [0:9];
   reg [15:0] lw = 16'h0000;
   reg [511:0] lim = 512'h0;
   wire req;
   wire [15:0] addr;
   wire vld;
   wire [15:0] rdat;
   wire ill;
   wire ezr;
   integer mismatches = 0;
   integer comparisons = 0;
   integer i;
   reg [15:0] d;
   reg [15:0] e;
   reg il;
   reg ez;
   reg to;
   initial
   begin
      for (i = 0; i < 10; i = i + 1)
         lv[i] = 16'h0000;
      forever #5 I_CLK = ~I_CLK;
   end
   weigh_status_bank weigh_status_bank_inst (.I_CLK(I_CLK), .I_RST(I_RST), .i_meas_we(we),
      .i_meas_scale(sc), .i_meas_sel(sl), .i_meas_data(md), .i_aout1(lv[0]),
      .i_aout2(lv[1]), .i_aout3(lv[2]), .i_aout4(lv[3]), .i_din_a(lv[4]), .i_din_b(lv[5]),
      .i_din_c(lv[6]), .i_dout_a(lv[7]), .i_dout_b(lv[8]), .i_dout_c(lv[9]),
      .i_level_weight(lw), .i_level_limits(lim), .i_rd_req(req), .i_rd_addr(addr),
      .o_rd_valid(vld), .o_rd_data(rdat), .o_rd_illegal(ill), .o_rd_err_zero(ezr));
   weigh_master_model weigh_master_model_inst (.i_clk(I_CLK), .o_rd_req(req),
      .o_rd_addr(addr), .i_rd_valid(vld), .i_rd_data(rdat), .i_rd_illegal(ill),
      .i_rd_err_zero(ezr));
   task give_verdict;
      begin
         if (mismatches == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   task cmp(input string nm, input [15:0] x, input [15:0] s);
      begin
         comparisons = comparisons + 1;
         if (s !== x)
         begin
            mismatches = mismatches + 1;
            $display("BAD %s expected %h seen %h", nm, x, s);
         end
         if (nm == "answer" && s !== x)
            give_verdict;
      end
   endtask
   task rd(input [15:0] a);
      begin
         weigh_master_model_inst.rd(a, d, il, ez, to);
         cmp("answer", 16'h0000, {15'h0, to});
      end
   endtask
   task wr(input [2:0] s, input [2:0] l, input [15:0] v);
      begin
         @(posedge I_CLK);
         #1 we = 1'b1;
         sc = s;
         sl = l;
         md = v;
         @(posedge I_CLK);
         #1 we = 1'b0;
      end
   endtask
   // ---------
   // scenarios
   // ---------
   task t_live;
      begin
         @(posedge I_CLK);
         #1;
         for (i = 0; i < 10; i = i + 1)
            lv[i] = (16'h0001 << i) | (16'h8000 >> i) | 16'h0300;
         for (i = 0; i < 10; i = i + 1)
         begin
            rd(i < 4 ? 16'h0040 + i : 16'h004C + i);
            cmp("live word", lv[i], d);
            cmp("live flag", 16'h0000, {14'h0, il, ez});
         end
      end
   endtask
   task t_meas;
      begin
         wr(3'h3, 3'h4, 16'h0000);
         for (i = 0; i < 5; i = i + 1)
         begin
            if (i < 4)
               wr(3'h3, i[2:0], 16'hA5A0 + i);
            else
               wr(3'h3, 3'h4, 16'h12FF);
            weigh_master_model_inst.rd_meas({3'h3, 3'h0} + (i < 4 ? i : 0), d, ez, e, to);
            cmp("answer", 16'h0000, {15'h0, to});
            cmp("value", i < 4 ? 16'hA5A0 + i : 16'hA5A0, d);
            cmp("error code", i < 4 ? 16'h0000 : 16'h00FF, e);
            cmp("error zero", i < 4 ? 16'h0001 : 16'h0000, {15'h0, ez});
         end
         rd(16'h001D);
         cmp("unmapped", 16'h0002, {14'h0, il, ez});
         rd(16'h0005);
         cmp("unmapped slot", 16'h0002, {14'h0, il, ez});
         rd(16'h0044);
         cmp("unmapped gap", 16'h0002, {14'h0, il, ez});
         rd(16'h0018);
         cmp("gross", 16'hA5A0, d);
         rd(16'h0060);
         cmp("unmapped data", 16'h0000, d);
         cmp("unmapped flags", 16'h0002, {14'h0, il, ez});
      end
   endtask
   task t_level;
      integer w;
      integer k;
      begin
         for (k = 0; k < 32; k = k + 1)
            lim[16*k +: 16] = (k == 20) ? 16'hFFFB : k * 10;
         for (w = 0; w < 2; w = w + 1)
         begin
            @(posedge I_CLK);
            #1 lw = w ? 16'hFFF6 : 16'h0096;
            rd(16'h0056);
            cmp("levels low", w ? 16'h0000 : 16'h7FFF, d);
            rd(16'h0057);
            cmp("levels high", w ? 16'h0000 : 16'h0010, d);
         end
      end
   endtask
   task t_reset;
      begin
         wr(3'h2, 3'h4, 16'h0005);
         rd(16'h0014);
         cmp("error code", 16'h0005, d);
         @(posedge I_CLK);
         #1 I_RST = 1'b1;
         @(posedge I_CLK);
         #1;
         cmp("reset data", 16'h0000, rdat);
         cmp("reset flags", 16'h0000, {13'h0, vld, ill, ezr});
         I_RST = 1'b0;
         rd(16'h0014);
         cmp("reset error", 16'h0000, d);
         cmp("error zero", 16'h0001, {15'h0, ez});
      end
   endtask
   initial
   begin
      repeat (5) @(posedge I_CLK);
      #1 I_RST = 1'b0;
      t_live;
      t_meas;
      t_level;
      t_reset;
      give_verdict;
   end
endmodule

// ---- tb/weigh_master_model.sv ----
// remote master model: one register read at a time
// assumes: answer comes within four edges of the request
`timescale 1ns/1ps
module weigh_master_model
(
   input wire i_clk,
   output reg o_rd_req,
   output reg [15:0] o_rd_addr,
   input wire i_rd_valid,
   input wire [15:0] i_rd_data,
   input wire i_rd_illegal,
   input wire i_rd_err_zero
);
   initial
   begin
      o_rd_req = 1'b0;
      o_rd_addr = 16'hFFFF;
   end
   task rd(input [15:0] a, output [15:0] d, output il, output ez, output to);
      integer n;
      begin
         to = 1'b1;
         @(posedge i_clk);
         #1 o_rd_req = 1'b1;
         o_rd_addr = a;
         @(posedge i_clk);
         #1 o_rd_req = 1'b0;
         o_rd_addr = ~a;
         for (n = 0; n < 4 && to; n = n + 1)
         begin
            @(posedge i_clk);
            #1;
            if (i_rd_valid === 1'b1)
            begin
               d = i_rd_data;
               il = i_rd_illegal;
               ez = i_rd_err_zero;
               to = 1'b0;
            end
         end
      end
   endtask
   task rd_meas(input [5:0] a, output [15:0] d, output ez, output [15:0] e, output to);
      reg il;
      reg x;
      reg t2;
      begin
         rd({10'h000, a}, d, il, ez, to);
         rd({10'h000, a[5:3], 3'h4}, e, il, x, t2);
         to = to | t2;
      end
   endtask
endmodule

// ---- tb/weigh_status_checker.sv ----
// checker: read port timing and register map of the status bank
// assumes: bound into weigh_status_bank, answers two edges after a request
`timescale 1ns/1ps
module weigh_status_checker
(
   input wire I_CLK,
   input wire I_RST,
   input wire [15:0] i_aout1,
   input wire [15:0] i_din_a,
   input wire [15:0] i_dout_c,
   input wire i_rd_req,
   input wire [15:0] i_rd_addr,
   input wire o_rd_valid,
   input wire [15:0] o_rd_data,
   input wire o_rd_illegal,
   input wire o_rd_err_zero
);
   // --------------------
   // read port properties
   // --------------------
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RST);
   sequence s_take(a);
      i_rd_req && i_rd_addr == a;
   endsequence
   sequence s_word(v);
      ##2 o_rd_valid && !o_rd_illegal && o_rd_data == v;
   endsequence
   chk_answer_delay: assert property (i_rd_req |-> ##2 o_rd_valid)
      else $error("answer late");
   chk_no_spurious: assert property (o_rd_valid |-> $past(i_rd_req, 2))
      else $error("answer without request");
   chk_data_holds: assert property (!o_rd_valid |-> $stable(o_rd_data))
      else $error("read data moved");
   chk_unmapped_zero: assert property (i_rd_req && i_rd_addr > 16'h0057
      |-> ##2 o_rd_illegal && o_rd_data == 16'h0000)
      else $error("unmapped read not refused");
   chk_err_scale: assert property (o_rd_err_zero
      |-> o_rd_valid && !o_rd_illegal && $past(i_rd_addr, 2) < 16'h0040)
      else $error("error flag on wrong answer");
   chk_inputs_a: assert property (s_take(16'h0050) |-> s_word($past(i_din_a, 3)))
      else $error("input word wrong");
   chk_outputs_c: assert property (s_take(16'h0055) |-> s_word($past(i_dout_c, 3)))
      else $error("output word wrong");
   chk_analog_one: assert property (s_take(16'h0040) |-> s_word($past(i_aout1, 3)))
      else $error("analog word wrong");
endmodule
bind weigh_status_bank weigh_status_checker weigh_status_checker_inst (.I_CLK, .I_RST,
   .i_aout1, .i_din_a, .i_dout_c, .i_rd_req, .i_rd_addr, .o_rd_valid, .o_rd_data,
   .o_rd_illegal, .o_rd_err_zero);
